// ===== src/qs_pkg.sv
// shared constants of the queue subsystem router
// assumes one clock domain and no software-reachable registers
package qs_pkg;
	localparam int QS_NQ_PER      = 8192;     // queues per manager
	localparam int QS_NQ_TOT      = 16384;    // queues in both managers
	localparam int QS_QW          = 14;       // physical queue number width
	localparam int QS_NRGN        = 64;       // regions per manager
	localparam int QS_LINK_INT    = 32768;    // internal linking entries
	localparam int QS_DESC_MAX    = 1048576;  // descriptors, all linking
	localparam int QS_DW          = 20;       // descriptor index width
	localparam int QS_LW          = 15;       // internal link index width
	localparam int QS_QSTRIDE_LOG2 = 4;       // log2 of push/pop bytes per queue (16)
	localparam int QS_OFFW        = 18;       // push/pop region offset
	localparam int QS_LQM_SPAN    = 4096;     // queues per logical manager
	localparam int QS_LQMW        = 2;        // logical manager number
	localparam int QS_LQNW        = 12;       // queue within logical mgr
	localparam int QS_NMC         = 8;        // packet microcontrollers
	localparam int QS_NDIST       = 2;        // interrupt distributors
	localparam int QS_TMR_W       = 16;       // microcontroller timer
	localparam int QS_BUF_DEPTH   = 2;        // data-bus request buffer
	localparam logic [15:0] QS_TMR_RST = 16'h0000;
endpackage : qs_pkg

// ===== src/qs_router.sv
// queue subsystem router: push/pop steering to two queue managers,
// logical manager translation, pending triggers, timers, interrupts
// assumes all inputs synchronous to clk; managers answer with ready
// How it works
// - two managers of 8192 queues each give 16384 addressable queues.
// - each manager keeps 64 descriptor region entries.
// - one internal linking RAM of 32K entries; each manager also external.
// - descriptor indices reach 1,024K across internal and external linking.
// - engine one triggered by first manager pending, engine two by second.
// - eight packet microcontrollers each own a dedicated timer.
// - two interrupt distributors, each serving two microcontroller pairs.
// - the second manager has its own port, free of first-manager traffic.
// - replicated instances sit at a regular stride from each other.
// - push/pop region is contiguous from the first manager base.
// - configuration blocks are not assumed contiguous.
// - split boundary in the internal linking RAM is programmable.
// - descriptor region sizes must be powers of two.
// - only packet DMA engines translate logical manager numbers.
// - translation also applies to receive flow manager and queue fields.
// - transmit queues follow a linear map from a per-engine base pointer.
// - config accesses steered to a port; data-bus accesses are queued.
`timescale 1ns/1ps
module qs_router #(
	parameter int NQ_PER    = qs_pkg::QS_NQ_PER,
	parameter int BUF_DEPTH = qs_pkg::QS_BUF_DEPTH,
	parameter int NMC       = qs_pkg::QS_NMC
) (
	input  wire logic                          clk,
	input  wire logic                          rstn,
	input  wire logic                          ce,
	input  wire logic                          split_mode,
	input  wire logic [qs_pkg::QS_LW-1:0]      split_point,
	input  wire logic [qs_pkg::QS_DW-1:0]      rgn_size,
	output logic                               rgn_size_bad,
	input  wire logic                          cfg_valid,
	output logic                               cfg_ready,
	input  wire logic                          cfg_pop,
	input  wire logic [qs_pkg::QS_OFFW-1:0]    cfg_off,
	input  wire logic [qs_pkg::QS_DW-1:0]      cfg_desc,
	input  wire logic                          dma_valid,
	output logic                               dma_ready,
	input  wire logic                          dma_eng,
	input  wire logic                          dma_pop,
	input  wire logic [qs_pkg::QS_LQMW-1:0]    dma_lqm,
	input  wire logic [qs_pkg::QS_LQNW-1:0]    dma_qnum,
	input  wire logic [qs_pkg::QS_DW-1:0]      dma_desc,
	input  wire logic [1:0][qs_pkg::QS_QW-1:0] lm_base_ptr,
	input  wire logic                          rxf_valid,
	input  wire logic                          rxf_eng,
	input  wire logic [qs_pkg::QS_LQMW-1:0]    rxf_lqm,
	input  wire logic [qs_pkg::QS_LQNW-1:0]    rxf_qnum,
	output logic [qs_pkg::QS_QW-1:0]           rxf_phys,
	output logic [1:0]                         qm_valid,
	input  wire logic [1:0]                    qm_ready,
	output logic [1:0]                         qm_pop,
	output logic [1:0][qs_pkg::QS_QW-2:0]      qm_qidx,
	output logic [1:0][qs_pkg::QS_DW-1:0]      qm_desc,
	output logic [1:0]                         qm_link_ext,
	output logic                               link_fault,
	input  wire logic [1:0]                    qm_pend,
	output logic [1:0]                         dma_trig,
	input  wire logic [NMC-1:0][qs_pkg::QS_TMR_W-1:0] mc_period,
	output logic [NMC-1:0]                     mc_tick,
	input  wire logic [NMC-1:0]                mc_evt,
	output logic [qs_pkg::QS_NDIST-1:0]        dist_irq
);
	localparam int QW = qs_pkg::QS_QW;
	localparam int DW = qs_pkg::QS_DW;
	localparam int EW = 1 + QW + DW;
	localparam int AW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;

	// sizes the logic cannot serve are refused while elaborating
	if (NQ_PER != qs_pkg::QS_NQ_PER ||
		NMC != qs_pkg::QS_NMC) begin : g_bad_cnt
		$error("queue or microcontroller count not served");
	end
	if (BUF_DEPTH != 2) begin : g_bad_depth
		$error("buffer depth must be two");
	end

	// queue number from push/pop offset; same arithmetic for both managers
	function automatic logic [QW-1:0] off_to_q(
		input logic [qs_pkg::QS_OFFW-1:0] off);
		off_to_q = off[qs_pkg::QS_QSTRIDE_LOG2 +: QW];
	endfunction : off_to_q

	// logical manager/queue to physical queue, linear in base pointer
	function automatic logic [QW-1:0] xlate(
		input logic [QW-1:0]               base,
		input logic [qs_pkg::QS_LQMW-1:0]  lqm,
		input logic [qs_pkg::QS_LQNW-1:0]  q);
		xlate = base + {lqm, q};
	endfunction : xlate

	function automatic logic is_pow2(input logic [DW-1:0] v);
		is_pow2 = (v != '0) && ((v & (v - 1'b1)) == '0);
	endfunction : is_pow2

	// configuration path bypasses the buffer, steered by queue number
	logic [QW-1:0] cfg_q;
	logic          cfg_dest;
	logic [1:0]    port_free;
	logic          cfg_go;
	// steering reads only the push/pop offset, never a config block address
	assign cfg_q     = off_to_q(cfg_off);
	assign cfg_dest  = cfg_q[QW-1];
	assign port_free = ~qm_valid | qm_ready;
	assign cfg_ready = port_free[cfg_dest];
	assign cfg_go    = ce && cfg_valid && cfg_ready;

	// two-entry buffer for data-bus traffic from the packet DMA engines
	// depth two keeps a stalled word while the next one is taken in
	logic [EW-1:0]    buf_mem [BUF_DEPTH];
	logic [AW-1:0]    wr_ptr_r;
	logic [AW-1:0]    rd_ptr_r;
	logic [AW:0]      cnt_r;
	logic             buf_valid;
	logic             buf_take;
	logic             buf_put;
	logic [EW-1:0]    head;
	logic [EW-1:0]    dma_ent;
	logic             hd_dest;

	assign buf_valid = (cnt_r != '0);
	assign dma_ready = (cnt_r != (AW+1)'(BUF_DEPTH));
	assign buf_put   = ce && dma_valid && dma_ready;
	assign head      = buf_mem[rd_ptr_r];
	assign hd_dest   = head[DW+QW-1];
	// only the engine translates; everything after sees physical numbers
	assign dma_ent   = {dma_pop, xlate(lm_base_ptr[dma_eng], dma_lqm,
		dma_qnum), dma_desc};
	// config wins a port it competes for; buffer holds the word meanwhile
	assign buf_take  = ce && buf_valid && port_free[hd_dest] &&
		!(cfg_valid && cfg_dest == hd_dest);

	always_ff @(posedge clk) begin
		if (buf_put)
			buf_mem[wr_ptr_r] <= dma_ent;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			cnt_r    <= '0;
		end else begin
			if (buf_put)
				wr_ptr_r <= wr_ptr_r + 1'b1;
			if (buf_take)
				rd_ptr_r <= rd_ptr_r + 1'b1;
			if (buf_put && !buf_take)
				cnt_r <= cnt_r + 1'b1;
			else if (!buf_put && buf_take)
				cnt_r <= cnt_r - 1'b1;
		end
	end

	// per-manager output stage; separate ports so managers never contend
	logic [1:0]          ld;
	logic [1:0][EW-1:0]  ld_ent;
	logic [1:0]          ld_bad;

	genvar p;
	generate
		for (p = 0; p < 2; p++) begin : g_port
			logic [QW-1:0] lq;
			logic [DW-1:0] ldesc;
			logic          lint;
			assign ld[p] = (cfg_go && cfg_dest == p) ||
				(buf_take && hd_dest == p);
			assign ld_ent[p] = (cfg_go && cfg_dest == p) ?
				{cfg_pop, cfg_q, cfg_desc} : head;
			assign lq    = ld_ent[p][DW +: QW];
			assign ldesc = ld_ent[p][DW-1:0];
			// indices below 32K live in the shared internal linking RAM
			assign lint  = (ldesc < DW'(qs_pkg::QS_LINK_INT));
			// split mode: first manager below the boundary, second at or above it
			assign ld_bad[p] = split_mode && lint && !ld_ent[p][EW-1] &&
				((p == 0) ? (ldesc[qs_pkg::QS_LW-1:0] >= split_point)
				          : (ldesc[qs_pkg::QS_LW-1:0] <  split_point));

			always_ff @(posedge clk or negedge rstn) begin
				if (!rstn) begin
					qm_valid[p]    <= 1'b0;
					qm_pop[p]      <= 1'b0;
					qm_qidx[p]     <= '0;
					qm_desc[p]     <= '0;
					qm_link_ext[p] <= 1'b0;
				end else if (ce) begin
					if (ld[p]) begin
						qm_valid[p]    <= 1'b1;
						qm_pop[p]      <= ld_ent[p][EW-1];
						qm_qidx[p]     <= lq[QW-2:0];
						qm_desc[p]     <= ldesc;
						qm_link_ext[p] <= !lint;
					end else if (qm_ready[p]) begin
						qm_valid[p] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			link_fault <= 1'b0;
		else if (ce)
			link_fault <= |(ld & ld_bad);
	end

	// receive flow fields go through the same mapping as transmit
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			rxf_phys <= '0;
		else if (ce && rxf_valid)
			rxf_phys <= xlate(lm_base_ptr[rxf_eng], rxf_lqm, rxf_qnum);
	end

	// region table entries themselves live in the managers; size checked here
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			rgn_size_bad <= 1'b0;
		else if (ce)
			rgn_size_bad <= !is_pow2(rgn_size);
	end

	// engine n is woken only by manager n pending signals
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			dma_trig <= '0;
		else if (ce)
			dma_trig <= qm_pend;
	end

	// one reload timer per microcontroller
	logic [NMC-1:0][qs_pkg::QS_TMR_W-1:0] tmr_r;
	logic [qs_pkg::QS_NDIST-1:0][NMC-1:0] dist_map;
	genvar i;
	generate
		for (i = 0; i < NMC; i++) begin : g_mc
			always_ff @(posedge clk or negedge rstn) begin
				if (!rstn) begin
					tmr_r[i]   <= qs_pkg::QS_TMR_RST;
					mc_tick[i] <= 1'b0;
				end else if (ce) begin
					mc_tick[i] <= (tmr_r[i] == '0);
					tmr_r[i]   <= (tmr_r[i] == '0) ? mc_period[i]
						: tmr_r[i] - 1'b1;
				end
			end
			// pairs alternate: pair 0,2 to distributor 0; 1,3 to 1
			assign dist_map[0][i] = (((i >> 1) & 1) == 0);
			assign dist_map[1][i] = (((i >> 1) & 1) == 1);
		end
	endgenerate

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			dist_irq <= '0;
		else if (ce) begin
			dist_irq[0] <= |(mc_evt & dist_map[0]);
			dist_irq[1] <= |(mc_evt & dist_map[1]);
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	a_route_first: assert property (
		ce && cfg_go && !cfg_q[QW-1] |=>
		qm_valid[0] && qm_qidx[0] == $past(cfg_q[QW-2:0]))
		else $error("low queue not routed to first manager");
	a_route_second: assert property (
		ce && cfg_go && cfg_q[QW-1] |=>
		qm_valid[1] && qm_qidx[1] == $past(cfg_q[QW-2:0]))
		else $error("high queue not routed to second manager");
	a_hold_stall: assert property (
		qm_valid[0] && !qm_ready[0] |=> qm_valid[0] && $stable(qm_desc[0]))
		else $error("stalled word lost at first port");
	a_buf_bound: assert property (
		cnt_r <= (AW+1)'(BUF_DEPTH) &&
		(cnt_r != (AW+1)'(BUF_DEPTH) || !dma_ready))
		else $error("buffer overfilled");
	a_pend_trigger: assert property (
		ce ##0 (qm_pend == 2'b10) |=> dma_trig == 2'b10)
		else $error("engine woken by wrong manager");
	a_rx_linear: assert property (
		ce && rxf_valid && rxf_lqm == 2'd1 |=>
		rxf_phys == $past(lm_base_ptr[rxf_eng]) + 14'h1000 +
		$past({2'b00, rxf_qnum}))
		else $error("receive flow mapping not linear");
	a_split_fault: assert property (
		ce && ld[1] && ld_bad[1] |=> link_fault)
		else $error("split boundary breach not flagged");
	a_timer_tick: assert property (
		ce && tmr_r[0] == '0 |=> mc_tick[0] && tmr_r[0] == $past(mc_period[0]))
		else $error("timer did not reload");
	a_dist_pair: assert property (
		ce && mc_evt == 8'h04 |=> dist_irq == 2'b10)
		else $error("event sent to wrong distributor");
	a_pow2_size: assert property (
		ce && rgn_size == 20'h00030 |=> rgn_size_bad)
		else $error("non power of two size accepted");
	// buffered words take the same steering as config words
	a_dma_route_low: assert property (
		buf_take && !hd_dest |=>
		qm_valid[0] && qm_qidx[0] == $past(head[DW +: QW-1]))
		else $error("buffered word not routed to first manager");
	a_dma_route_high: assert property (
		buf_take && hd_dest |=>
		qm_valid[1] && qm_qidx[1] == $past(head[DW +: QW-1]))
		else $error("buffered word not routed to second manager");
	a_hold_second: assert property (
		qm_valid[1] && !qm_ready[1] |=>
		qm_valid[1] && $stable(qm_desc[1]) && $stable(qm_qidx[1]))
		else $error("stalled word lost at second port");
	a_link_select: assert property (
		ld[0] |=> qm_link_ext[0] ==
		($past(ld_ent[0][DW-1:0]) >= DW'(qs_pkg::QS_LINK_INT)))
		else $error("linking RAM choice wrong at first port");
	a_shared_quiet: assert property (
		ce && !split_mode |=> !link_fault)
		else $error("fault flagged in shared mode");
	a_trig_first: assert property (
		ce && qm_pend == 2'b01 |=> dma_trig == 2'b01)
		else $error("engine one not woken by first manager");
	a_dist_first: assert property (
		ce && mc_evt == 8'h11 |=> dist_irq == 2'b01)
		else $error("pair event sent to wrong distributor");
	a_pow2_pass: assert property (
		ce && rgn_size == 20'h00040 |=> !rgn_size_bad)
		else $error("power of two size refused");
	// a frozen cycle must leave the port valids, timer ticks and distributor requests as they were
	a_ce_freeze: assert property (
		!ce |=> $stable(qm_valid) && $stable(mc_tick) &&
		$stable(dist_irq))
		else $error("state moved while clock enable low");
endmodule : qs_router

// ===== verification/qs_qm_model.sv
// queue manager stand-in: accepts words on both router ports
// assumes the router holds each word until ready is seen at an edge
`timescale 1ns/1ps
module qs_qm_model (
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic       slow,
	output logic      [1:0] qm_ready
);
	logic [2:0] cnt_r;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_r <= 3'h0;
		end else begin
			cnt_r <= cnt_r + 3'h1;
		end
	end

	// in slow mode the ports are ready on different beats, so a buffered word for one can wait behind a word for the other; otherwise both are always ready
	assign qm_ready = slow ? {cnt_r == 3'h2, cnt_r[1:0] == 2'h0} : 2'h3;
endmodule : qs_qm_model

// ===== verification/qs_tb.sv
// self-checking bench for the queue subsystem router
// assumes qs_pkg and the manager stand-in are compiled first
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
	n_mismatch++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module testbench;
	logic             clk, rstn, ce, split_mode, slow, rgn_size_bad;
	logic             cfg_valid, cfg_ready, cfg_pop, dma_valid, dma_ready;
	logic             dma_eng, dma_pop, rxf_valid, rxf_eng, link_fault;
	logic [14:0]      split_point;
	logic [19:0]      rgn_size, cfg_desc, dma_desc;
	logic [17:0]      cfg_off;
	logic [1:0]       dma_lqm, rxf_lqm, qm_valid, qm_ready, qm_pop;
	logic [1:0]       qm_link_ext, qm_pend, dma_trig, dist_irq;
	logic [11:0]      dma_qnum, rxf_qnum;
	logic [13:0]      rxf_phys;
	logic [1:0][13:0] lm_base_ptr;
	logic [1:0][12:0] qm_qidx;
	logic [1:0][19:0] qm_desc;
	logic [7:0][15:0] mc_period;
	logic [7:0]       mc_tick, mc_evt;
	logic [34:0]      expq[2][$];
	logic [34:0]      w;
	logic [31:0]      r;
	int               n_mismatch, total_checks, nflt, eflt, ntick[8];
	bit               tick_on;
	logic [13:0]      edge_q[6] = '{14'h0000, 14'h1fff, 14'h2000, 14'h3fff,
		14'h0064, 14'h2710};

	qs_router dut_u (.clk, .rstn, .ce, .split_mode, .split_point, .rgn_size,
		.rgn_size_bad, .cfg_valid, .cfg_ready, .cfg_pop, .cfg_off, .cfg_desc,
		.dma_valid, .dma_ready, .dma_eng, .dma_pop, .dma_lqm, .dma_qnum,
		.dma_desc, .lm_base_ptr, .rxf_valid, .rxf_eng, .rxf_lqm, .rxf_qnum,
		.rxf_phys, .qm_valid, .qm_ready, .qm_pop, .qm_qidx, .qm_desc,
		.qm_link_ext, .link_fault, .qm_pend, .dma_trig, .mc_period, .mc_tick,
		.mc_evt, .dist_irq);
	qs_qm_model qm_u (.clk, .rstn, .slow, .qm_ready);

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task automatic close_out;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : close_out

	// d selects the data-bus handshake; ce low means no transfer
	task automatic hs(input bit d);
		int n;
		for (n = 0; n < 64; n++) begin
			@(posedge clk);
			if ((d ? dma_ready : cfg_ready) === 1'b1 && ce === 1'b1) break;
			// a stall cycle draws a new enable, so a frozen cycle cannot hang
			r = lfsr(r);
			ce <= r[0] | r[1];
		end
		if (n == 64) begin
			n_mismatch++;
			close_out();
		end
	endtask : hs

	task automatic note(input logic [13:0] q, input logic [19:0] d,
			input logic p);
		expq[q[13]].push_back({p, d >= 20'h08000, q[12:0], d});
		if (split_mode && !p && d < 20'h08000
				&& ((d[14:0] >= split_point) != q[13])) eflt++;
		r = lfsr(r);
		ce <= r[0] | r[1];
	endtask : note

	task automatic cfg_req(input logic [13:0] q, input logic [19:0] d,
			input logic p);
		cfg_valid <= 1'b1;
		cfg_off <= {q, 4'h0};
		cfg_desc <= d;
		cfg_pop <= p;
		hs(0);
		note(q, d, p);
	endtask : cfg_req

	task automatic dma_req(input logic e, input logic [1:0] l,
			input logic [11:0] qn, input logic [19:0] d, input logic p);
		logic [13:0] ph;
		ph = lm_base_ptr[e] + {l, 12'h000} + {2'b00, qn};
		dma_valid <= 1'b1;
		dma_eng <= e;
		dma_lqm <= l;
		dma_qnum <= qn;
		dma_desc <= d;
		dma_pop <= p;
		hs(1);
		note(ph, d, p);
	endtask : dma_req

	task automatic drain;
		int n;
		for (n = 0; n < 400; n++) begin
			@(posedge clk);
			if (expq[0].size() + expq[1].size() == 0) break;
		end
		if (n == 400) begin
			n_mismatch++;
			close_out();
		end
		repeat (3) @(posedge clk);
		`CHK("link_fault", eflt, nflt)
	endtask : drain

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// a frozen pulse is counted once, at the ce edge that ends it
	always @(posedge clk) begin
		if (rstn === 1'b1 && ce === 1'b1) begin
			if (link_fault === 1'b1) nflt++;
			for (int i = 0; i < 2; i++) begin
				if (qm_valid[i] === 1'b1 && qm_ready[i] === 1'b1) begin
					w = expq[i].size() ? expq[i].pop_front() : 'x;
					`CHK("qm word", w, {qm_pop[i], qm_link_ext[i], qm_qidx[i], qm_desc[i]})
				end
			end
			for (int i = 0; i < 8; i++) if (tick_on) ntick[i] += mc_tick[i];
		end
	end

	initial begin
		{rstn, ce, split_mode, slow, cfg_valid, cfg_pop, dma_valid} = '0;
		{dma_eng, dma_pop, rxf_valid, rxf_eng, qm_pend, mc_evt} = '0;
		{split_point, rgn_size, cfg_desc, dma_desc, cfg_off} = '0;
		{dma_lqm, rxf_lqm, dma_qnum, rxf_qnum} = '0;
		lm_base_ptr = '0;
		for (int i = 0; i < 8; i++) mc_period[i] = 16'(i);
		r = 32'd43;
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		ce <= 1'b1;
		for (int m = 0; m < 2; m++) begin
			@(posedge clk);
			split_mode <= m[0];
			slow <= m[0];
			split_point <= m ? 15'h1800 : 15'h4000;
			if (m) lm_base_ptr <= {r[13:0], r[27:14]};
			@(posedge clk);
			foreach (edge_q[k])
				cfg_req(edge_q[k], {5'h0, r[14:0]}, 1'b0);
			for (int k = 0; k < 12; k++) begin
				r = lfsr(r);
				cfg_req(r[13:0], r[4] ? {5'h0, r[26:12]} : r[31:12], r[3]);
			end
			cfg_valid <= 1'b0;
			for (int k = 0; k < 12; k++) begin
				r = lfsr(r);
				dma_req(r[0], r[2:1], r[14:3], r[5] ? {5'h0, r[31:17]}
					: r[31:12], r[6]);
			end
			dma_valid <= 1'b0;
			@(posedge clk);
			ce <= 1'b1;
			drain();
		end
		for (int k = 0; k < 16; k++) begin
			r = lfsr(r);
			@(posedge clk);
			rxf_valid <= 1'b1;
			rxf_eng <= r[0];
			rxf_lqm <= r[2:1];
			rxf_qnum <= r[14:3];
			qm_pend <= r[16:15];
			mc_evt <= r[24:17];
			rgn_size <= r[25] ? 20'h1 << (r[30:26] % 20) : r[19:0] | 20'h1;
			@(posedge clk);
			#1;
			`CHK("rxf_phys", lm_base_ptr[rxf_eng] + {rxf_lqm, 12'h0} + rxf_qnum, rxf_phys)
			`CHK("dma_trig", qm_pend, dma_trig)
			`CHK("dist_irq", {|(mc_evt & 8'hcc), |(mc_evt & 8'h33)}, dist_irq)
			`CHK("rgn_bad", $countones(rgn_size) != 1, rgn_size_bad)
		end
		@(posedge clk);
		tick_on <= 1'b1;
		repeat (840) @(posedge clk);
		tick_on <= 1'b0;
		@(posedge clk);
		for (int i = 0; i < 8; i++) `CHK("mc_tick", 840 / (i + 1), ntick[i])
		close_out();
	end
endmodule : testbench
